// [fe_tx_cfg.svh]
// constants for the fast ethernet transmit mac and pcs
`ifndef FE_TX_CFG_SVH
`define FE_TX_CFG_SVH

// bit pacing: 125 MHz bit rate from 200 MHz clock, step 5 of 8
`define CLK_MHZ         16'h00C8
`define BIT_MHZ         16'h007D
`define ACC_STEP        3'h5
`define BITS_PER_GROUP  3'h4
// frame fields, nibbles go low half first
`define PRE_NIBBLE      4'h5
`define SFD_HI_NIBBLE   4'hD
`define PRE_LAST_NIB    5'h0F
`define LEN_MAX         16'h05DC
`define MIN_FRAME       11'h03C
`define MAX_FRAME       11'h5EA
`define TYPE_HI_IDX     11'h00C
`define TYPE_LO_IDX     11'h00D
`define CRC_INIT        32'hFFFFFFFF
`define CRC_POLY        32'hEDB88320
`define FCS_LAST_NIB    5'h07
// special code-groups
`define CODE_J          5'h18
`define CODE_K          5'h11
`define CODE_T          5'h0D
`define CODE_R          5'h07
`define CODE_IDLE       5'h1F
// gap parts in bit times, four bits per nibble
`define GAP_FIRST_BITS  8'h40
`define GAP_SECOND_BITS 8'h20
`define GAP_FIRST_NIB   5'(`GAP_FIRST_BITS >> 2)
`define GAP_TOTAL_NIB   5'((`GAP_FIRST_BITS + `GAP_SECOND_BITS) >> 2)
// collision handling
`define JAM_LAST_NIB    5'h07
`define SLOT_LAST_NIB   7'h7F
`define BACKOFF_LIMIT   4'hA
`define ATTEMPT_MAX     5'h10
// seeds, values arbitrary but non-zero
`define SCR_SEED        10'h2B5
`define LFSR_SEED       16'hACE1

`endif

// [fe_tx_pkg.sv]
// types shared by the fast ethernet transmit block
package fe_tx_pkg;

    typedef enum logic [3:0] {
        MAC_IDLE    = 4'h0,
        MAC_PRE     = 4'h1,
        MAC_DATA    = 4'h3,
        MAC_PAD     = 4'h2,
        MAC_FCS     = 4'h6,
        MAC_END     = 4'h7,
        MAC_JAM     = 4'h5,
        MAC_BACKOFF = 4'h4
    } mac_state_t;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'h0,
        RX_SAW_J = 2'h1,
        RX_FRAME = 2'h3,
        RX_SAW_T = 2'h2
    } rx_state_t;

    typedef struct packed {
        mac_state_t state;
        logic [4:0]  nibCnt;
        logic [7:0]  holdByte;
        logic        holdValid;
        logic        holdLast;
        logic        gotLast;
        logic [7:0]  curByte;
        logic        hiPhase;
        logic        lastInFrame;
        logic [10:0] byteCount;
        logic [31:0] crc;
        logic [7:0]  lenHi;
        logic [4:0]  gapCnt;
        logic [4:0]  attempt;
        logic [9:0]  slotLeft;
        logic [6:0]  slotNib;
        logic [15:0] lfsr;
        logic        drain;
        logic [2:0]  acc;
        logic [2:0]  bitIdx;
        logic [4:0]  shift;
        logic [10:0] scr;
        logic        nrzi;
        logic        lineIn;
        logic [1:0]  mltPhase;
        rx_state_t   rxState;
        logic [4:0]  rxS1;
        logic [4:0]  rxS2;
        logic        togS1;
        logic        togS2;
        logic        togS3;
        logic        crsS1;
        logic        crsS2;
        logic        colS1;
        logic        colS2;
        logic        txReady;
        logic        txRestart;
        logic        txDone;
        logic        txExcessive;
        logic        txIsType;
        logic [3:0]  miiTxd;
        logic        miiTxEn;
        logic        mltPos;
        logic        mltNeg;
        logic        rxInFrame;
        logic        rxAbort;
        logic        rxCrcError;
        logic        rxGood;
    } fe_state_t;

endpackage : fe_tx_pkg

// [fast_ethernet_mac_tx_pcs.sv]
// transmit mac framer, deferral, back-off and 100 Mb/s pcs to mlt3
`timescale 1ns/1ps
`include "fe_tx_cfg.svh"

module fast_ethernet_mac_tx_pcs (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic       txLast,
    input  wire logic       txPadDisable,
    input  wire logic       nrziEnable,
    input  wire logic       carrierSense,
    input  wire logic       collision,
    input  wire logic [4:0] rxCode,
    input  wire logic       rxCodeToggle,
    output logic            txReady,
    output logic            txRestart,
    output logic            txDone,
    output logic            txExcessive,
    output logic            txIsType,
    output logic [3:0]      miiTxd,
    output logic            miiTxEn,
    output logic            mltPos,
    output logic            mltNeg,
    output logic            rxInFrame,
    output logic            rxAbort,
    output logic            rxCrcError,
    output logic            rxGood
);

    fe_tx_pkg::fe_state_t s;
    fe_tx_pkg::fe_state_t next_s;

    // 4B/5B data table
    function automatic logic [4:0] encode4b5b(input logic [3:0] nib);
        logic [4:0] c;
        case (nib)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction : encode4b5b

    // true when a received group is one of the sixteen data groups
    function automatic logic isDataCode(input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (encode4b5b(4'(i)) == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : isDataCode

    // reflected crc-32, one byte, lsb first
    function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crcByte

    // next-state logic for the whole block
    always_comb begin
        logic [3:0]  sum;
        logic        bitTick;
        logic        groupTick;
        logic [4:0]  code;
        logic [3:0]  nib;
        logic        carry;
        logic        txBit;
        logic        scrBit;
        logic        lineBit;
        logic        sending;
        logic [4:0]  attemptNew;
        logic [3:0]  k;
        logic [10:0] mask;
        logic [4:0]  rxNow;
        next_s = s;
        sum = 4'({1'b0, s.acc} + {1'b0, `ACC_STEP});
        bitTick = sum[3];
        groupTick = bitTick && (s.bitIdx == `BITS_PER_GROUP);
        code = `CODE_IDLE;
        nib = 4'h0;
        carry = 1'b0;
        txBit = 1'b0;
        scrBit = 1'b0;
        lineBit = 1'b0;
        attemptNew = 5'h00;
        k = 4'h0;
        mask = 11'h000;
        rxNow = s.rxS2;
        sending = (s.state == fe_tx_pkg::MAC_PRE) || (s.state == fe_tx_pkg::MAC_DATA) ||
                  (s.state == fe_tx_pkg::MAC_PAD) || (s.state == fe_tx_pkg::MAC_FCS);
        next_s.acc = sum[2:0];
        next_s.txRestart = 1'b0;
        next_s.txDone = 1'b0;
        next_s.txExcessive = 1'b0;
        next_s.rxAbort = 1'b0;
        next_s.rxCrcError = 1'b0;
        next_s.rxGood = 1'b0;
        next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

        // pin synchronisers, second stage is read, toggle also through a third stage for edge detect
        next_s.crsS1 = carrierSense;
        next_s.crsS2 = s.crsS1;
        next_s.colS1 = collision;
        next_s.colS2 = s.colS1;
        next_s.rxS1 = rxCode;
        next_s.rxS2 = s.rxS1;
        next_s.togS1 = rxCodeToggle;
        next_s.togS2 = s.togS1;
        next_s.togS3 = s.togS2;

        // host byte handshake into the one-byte holding register
        if (s.txReady && txValid) begin
            if (s.drain) begin
                next_s.drain = !txLast;
            end else begin
                next_s.holdByte = txData;
                next_s.holdValid = 1'b1;
                next_s.holdLast = txLast;
                next_s.gotLast = txLast;
            end
        end

        if (groupTick) begin
            if (sending || s.state == fe_tx_pkg::MAC_END || s.state == fe_tx_pkg::MAC_JAM) begin
                next_s.gapCnt = 5'h00;
            end else if (s.gapCnt < `GAP_FIRST_NIB && s.crsS2) begin
                next_s.gapCnt = 5'h00;
            end else if (s.gapCnt != `GAP_TOTAL_NIB) begin
                next_s.gapCnt = 5'(s.gapCnt + 5'h01);
            end

            if (sending && s.colS2) begin
                // collision cuts the frame short, jam follows
                next_s.state = fe_tx_pkg::MAC_JAM;
                next_s.nibCnt = 5'h00;
                code = encode4b5b(`PRE_NIBBLE);
            end else begin
                case (s.state)
                    fe_tx_pkg::MAC_IDLE: begin
                        // idle groups keep the line alive
                        code = `CODE_IDLE;
                        if (txValid && !s.drain && s.gapCnt == `GAP_TOTAL_NIB) begin
                            next_s.state = fe_tx_pkg::MAC_PRE;
                            next_s.nibCnt = 5'h00;
                            next_s.crc = `CRC_INIT;
                            next_s.byteCount = 11'h000;
                            next_s.hiPhase = 1'b0;
                            next_s.gotLast = 1'b0;
                            next_s.holdValid = 1'b0;
                            next_s.txIsType = 1'b0;
                        end
                    end
                    fe_tx_pkg::MAC_PRE: begin
                        // first byte goes out as J/K
                        nib = (s.nibCnt == `PRE_LAST_NIB) ? `SFD_HI_NIBBLE : `PRE_NIBBLE;
                        if (s.nibCnt == 5'h00) begin
                            code = `CODE_J;
                        end else if (s.nibCnt == 5'h01) begin
                            code = `CODE_K;
                        end else begin
                            code = encode4b5b(nib);
                        end
                        next_s.nibCnt = 5'(s.nibCnt + 5'h01);
                        if (s.nibCnt == `PRE_LAST_NIB) begin
                            next_s.state = fe_tx_pkg::MAC_DATA;
                        end
                    end
                    fe_tx_pkg::MAC_DATA: begin
                        if (!s.hiPhase) begin
                            if (!s.holdValid) begin
                                // underrun: jam and retry like a collision
                                next_s.state = fe_tx_pkg::MAC_JAM;
                                next_s.nibCnt = 5'h00;
                                code = encode4b5b(`PRE_NIBBLE);
                            end else begin
                                next_s.crc = crcByte(s.crc, s.holdByte);
                                next_s.curByte = s.holdByte;
                                next_s.holdValid = 1'b0;
                                next_s.lastInFrame = s.holdLast ||
                                    (11'(s.byteCount + 11'h001) == `MAX_FRAME);
                                next_s.byteCount = 11'(s.byteCount + 11'h001);
                                if (s.byteCount == `TYPE_HI_IDX) begin
                                    next_s.lenHi = s.holdByte;
                                end
                                if (s.byteCount == `TYPE_LO_IDX) begin
                                    next_s.txIsType = {s.lenHi, s.holdByte} > `LEN_MAX;
                                end
                                nib = s.holdByte[3:0];
                                code = encode4b5b(nib);
                                next_s.hiPhase = 1'b1;
                            end
                        end else begin
                            nib = s.curByte[7:4];
                            code = encode4b5b(nib);
                            next_s.hiPhase = 1'b0;
                            if (s.lastInFrame) begin
                                // truncated frame: swallow the host's remainder
                                next_s.holdValid = 1'b0;
                                // a last byte taken in this very cycle must not start a drain
                                next_s.drain = !next_s.gotLast;
                                next_s.nibCnt = 5'h00;
                                if (!txPadDisable && s.byteCount < `MIN_FRAME) begin
                                    next_s.state = fe_tx_pkg::MAC_PAD;
                                end else begin
                                    next_s.state = fe_tx_pkg::MAC_FCS;
                                end
                            end
                        end
                    end
                    fe_tx_pkg::MAC_PAD: begin
                        code = encode4b5b(4'h0);
                        next_s.hiPhase = !s.hiPhase;
                        if (!s.hiPhase) begin
                            next_s.crc = crcByte(s.crc, 8'h00);
                            next_s.byteCount = 11'(s.byteCount + 11'h001);
                        end else if (s.byteCount >= `MIN_FRAME) begin
                            next_s.state = fe_tx_pkg::MAC_FCS;
                        end
                    end
                    fe_tx_pkg::MAC_FCS: begin
                        nib = ~s.crc[3:0];
                        code = encode4b5b(nib);
                        next_s.crc = s.crc >> 4;
                        next_s.nibCnt = 5'(s.nibCnt + 5'h01);
                        if (s.nibCnt == `FCS_LAST_NIB) begin
                            next_s.state = fe_tx_pkg::MAC_END;
                            next_s.nibCnt = 5'h00;
                        end
                    end
                    fe_tx_pkg::MAC_END: begin
                        // T then R right after check value
                        code = (s.nibCnt == 5'h00) ? `CODE_T : `CODE_R;
                        next_s.nibCnt = 5'(s.nibCnt + 5'h01);
                        if (s.nibCnt != 5'h00) begin
                            next_s.state = fe_tx_pkg::MAC_IDLE;
                            next_s.txDone = 1'b1;
                            next_s.attempt = 5'h00;
                        end
                    end
                    fe_tx_pkg::MAC_JAM: begin
                        code = encode4b5b(`PRE_NIBBLE);
                        next_s.nibCnt = 5'(s.nibCnt + 5'h01);
                        if (s.nibCnt == `JAM_LAST_NIB) begin
                            attemptNew = 5'(s.attempt + 5'h01);
                            next_s.holdValid = 1'b0;
                            if (attemptNew == `ATTEMPT_MAX) begin
                                // give up, drop what is left of the frame
                                next_s.state = fe_tx_pkg::MAC_IDLE;
                                next_s.attempt = 5'h00;
                                next_s.txExcessive = 1'b1;
                                next_s.drain = !next_s.gotLast;
                            end else begin
                                k = (attemptNew > 5'(`BACKOFF_LIMIT)) ? `BACKOFF_LIMIT : attemptNew[3:0];
                                mask = 11'((11'h001 << k) - 11'h001);
                                next_s.attempt = attemptNew;
                                next_s.slotLeft = s.lfsr[9:0] & mask[9:0];
                                next_s.slotNib = 7'h00;
                                next_s.state = fe_tx_pkg::MAC_BACKOFF;
                                next_s.txRestart = 1'b1;
                            end
                        end
                    end
                    fe_tx_pkg::MAC_BACKOFF: begin
                        code = `CODE_IDLE;
                        if (s.slotLeft == 10'h000) begin
                            next_s.state = fe_tx_pkg::MAC_IDLE;
                        end else begin
                            next_s.slotNib = 7'(s.slotNib + 7'h01);
                            if (s.slotNib == `SLOT_LAST_NIB) begin
                                next_s.slotLeft = 10'(s.slotLeft - 10'h001);
                            end
                        end
                    end
                    default: begin
                        code = `CODE_IDLE;
                        next_s.state = fe_tx_pkg::MAC_IDLE;
                    end
                endcase
            end
            // nibble taken on this edge, then encoded
            next_s.miiTxd = nib;
            // enable covers the slots that carry preamble through check value
            next_s.miiTxEn = sending;
        end

        // ready only while a frame is pulling bytes, or while draining
        next_s.txReady = next_s.drain ||
            (((next_s.state == fe_tx_pkg::MAC_PRE) || (next_s.state == fe_tx_pkg::MAC_DATA)) &&
             !next_s.holdValid && !next_s.gotLast);

        if (bitTick) begin
            // five bits per group at bit rate
            txBit = s.shift[4];
            next_s.shift = groupTick ? code : {s.shift[3:0], 1'b0};
            next_s.bitIdx = groupTick ? 3'h0 : 3'(s.bitIdx + 3'h1);
            carry = s.scr[10] ^ s.scr[8];
            next_s.scr = {s.scr[9:0], carry};
            scrBit = txBit ^ carry;
            // nrzi unless the enable is cleared
            lineBit = nrziEnable ? (s.nrzi ^ scrBit) : scrBit;
            next_s.nrzi = nrziEnable ? lineBit : s.nrzi;
            next_s.lineIn = lineBit;
            // mlt3 steps on every input change
            if (lineBit != s.lineIn) begin
                next_s.mltPhase = 2'(s.mltPhase + 2'h1);
            end
        end
        next_s.mltPos = (next_s.mltPhase == 2'h1);
        next_s.mltNeg = (next_s.mltPhase == 2'h3);

        // receive delimiter check, one group per toggle edge
        if (s.togS2 != s.togS3) begin
            case (s.rxState)
                fe_tx_pkg::RX_HUNT: begin
                    if (rxNow == `CODE_J) begin
                        next_s.rxState = fe_tx_pkg::RX_SAW_J;
                    end else if (rxNow != `CODE_IDLE) begin
                        next_s.rxAbort = 1'b1;
                    end
                end
                fe_tx_pkg::RX_SAW_J: begin
                    if (rxNow == `CODE_K) begin
                        next_s.rxState = fe_tx_pkg::RX_FRAME;
                    end else begin
                        next_s.rxAbort = 1'b1;
                        next_s.rxState = fe_tx_pkg::RX_HUNT;
                    end
                end
                fe_tx_pkg::RX_FRAME: begin
                    // frame ending without T is bad
                    if (rxNow == `CODE_T) begin
                        next_s.rxState = fe_tx_pkg::RX_SAW_T;
                    end else if (!isDataCode(rxNow)) begin
                        next_s.rxCrcError = 1'b1;
                        next_s.rxState = fe_tx_pkg::RX_HUNT;
                    end
                end
                default: begin
                    // T must be followed by R
                    next_s.rxGood = (rxNow == `CODE_R);
                    next_s.rxCrcError = (rxNow != `CODE_R);
                    next_s.rxState = fe_tx_pkg::RX_HUNT;
                end
            endcase
        end
        next_s.rxInFrame = (next_s.rxState == fe_tx_pkg::RX_FRAME) ||
                           (next_s.rxState == fe_tx_pkg::RX_SAW_T);
    end

    // single state register, seeds loaded at reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.scr <= {1'b1, `SCR_SEED};
            s.lfsr <= `LFSR_SEED;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign txReady     = s.txReady;
    assign txRestart   = s.txRestart;
    assign txDone      = s.txDone;
    assign txExcessive = s.txExcessive;
    assign txIsType    = s.txIsType;
    assign miiTxd      = s.miiTxd;
    assign miiTxEn     = s.miiTxEn;
    assign mltPos      = s.mltPos;
    assign mltNeg      = s.mltNeg;
    assign rxInFrame   = s.rxInFrame;
    assign rxAbort     = s.rxAbort;
    assign rxCrcError  = s.rxCrcError;
    assign rxGood      = s.rxGood;

endmodule : fast_ethernet_mac_tx_pcs

// [fe_tx_sva.sv]
// port assertions for the transmit mac and pcs
`timescale 1ns/1ps
module fe_tx_sva (
    input wire logic clk, arst_n, txValid, txReady, txDone, miiTxEn,
    input wire logic mltPos, mltNeg, rxGood, rxCrcError, rxAbort, rxInFrame
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_line_levels: assert property (!(mltPos && mltNeg)) else $error("line both levels");
    a_mlt_step: assert property (mltPos |=> !mltNeg) else $error("line skipped zero");
    a_take_drop: assert property (txReady && txValid |=> !txReady) else $error("ready held");
    a_done_pulse: assert property (txDone |=> !txDone) else $error("done too long");
    a_done_quiet: assert property (txDone |-> !miiTxEn) else $error("enable at done");
    a_pre_hold: assert property ($rose(miiTxEn) |-> miiTxEn [*8]) else $error("short slot");
    a_rx_good: assert property (rxGood |-> !rxCrcError && !rxAbort) else $error("good with error");
    a_abort_out: assert property (rxAbort |-> !rxInFrame) else $error("abort in frame");
endmodule : fe_tx_sva
bind fast_ethernet_mac_tx_pcs fe_tx_sva chk (.clk, .arst_n, .txValid, .txReady, .txDone, .miiTxEn, .mltPos,
    .mltNeg, .rxGood, .rxCrcError, .rxAbort, .rxInFrame);

// [fe_far_partner.sv]
// far-side link partner: line watch, carrier, collision, codes
`timescale 1ns/1ps
module fe_far_partner (
    input  wire logic  clk,
    input  wire logic  mltPos,
    input  wire logic  mltNeg,
    output logic       carrierSense,
    output logic       collision,
    output logic [4:0] rxCode,
    output logic       rxCodeToggle
);
    int lineSeen = 0;
    // any nonzero line level means the link is live
    always @(posedge clk) lineSeen += (mltPos || mltNeg);
    initial {carrierSense, collision, rxCode, rxCodeToggle} = 8'h3E;
    task automatic sendCode(input logic [4:0] c);
        rxCode = c;
        repeat (5) @(posedge clk);
        #1 rxCodeToggle = ~rxCodeToggle;
        repeat (5) @(posedge clk);
        #1 rxCode = ~c; // stale code not left standing
    endtask : sendCode
endmodule : fe_far_partner

// [fast_ethernet_mac_tx_pcs_tb_top.sv]
// self-checking bench for the transmit mac and pcs
`timescale 1ns/1ps
`include "fe_tx_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t mismatch", $time); end end
module fast_ethernet_mac_tx_pcs_tb_top;
    logic       clk = 0, arst_n = 0, txValid = 0, txLast = 0, txPadDisable = 0, nrziEnable = 0;
    logic [7:0] txData = 8'h00;
    logic       txReady, txRestart, txDone, txExcessive, txIsType, miiTxEn, mltPos, mltNeg, rxInFrame;
    logic       rxAbort, rxCrcError, rxGood, carrierSense, collision, rxCodeToggle;
    logic [3:0] miiTxd;
    logic [4:0] rxCode;
    int         fails = 0, n_compared = 0, cyc = 0, nRestart = 0, nGood = 0, nCrc = 0, nAbort = 0, enCnt = 0;
    fast_ethernet_mac_tx_pcs uut (.clk, .arst_n, .txData, .txValid, .txLast, .txPadDisable, .nrziEnable,
        .carrierSense, .collision, .rxCode, .rxCodeToggle, .txReady, .txRestart, .txDone, .txExcessive,
        .txIsType, .miiTxd, .miiTxEn, .mltPos, .mltNeg, .rxInFrame, .rxAbort, .rxCrcError, .rxGood);
    fe_far_partner far (.clk, .mltPos, .mltNeg, .carrierSense, .collision, .rxCode, .rxCodeToggle);
    initial forever #2.5 clk = ~clk;
    // pulse counters and a hang guard
    always @(posedge clk) begin
        cyc++;
        enCnt += (miiTxEn === 1'h1);
        nRestart += (txRestart === 1'h1);
        nGood += (rxGood === 1'h1);
        nCrc += (rxCrcError === 1'h1);
        nAbort += (rxAbort === 1'h1);
        if (cyc == 40000) begin fails++; finish_test(); end
    end
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // idle line must stay live, nrzi off then on
    task automatic idleLine();
        far.lineSeen = 0; tick(200);
        `CHK(far.lineSeen > 0, 1'h1)
        nrziEnable = 1; far.lineSeen = 0; tick(200);
        `CHK(far.lineSeen > 0, 1'h1)
        `CHK(txReady, 1'h0)
    endtask : idleLine
    // frame length in slots (8 clk each) shows pad, preamble and check value
    task automatic sendFrame(input int nb, input logic padOff, input logic [15:0] lt, input bit hit);
        int i = 0, exp;
        logic rdy;
        exp = (16 + 2 * ((padOff || nb > 59) ? nb : 60) + 8) * 8;
        enCnt = 0; nRestart = 0; txPadDisable = padOff; txValid = 1;
        fork
            // collision held past one whole group slot so a slot tick sees it
            if (hit) begin wait (miiTxEn); tick(150); far.collision = 1; tick(10); far.collision = 0; end
        join_none
        // rewind to the first byte whenever a restart is signalled
        while (i < nb) begin
            txData = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : 8'(i);
            txLast = (i == nb - 1);
            // ready as the design will sample it at the coming edge
            rdy = txReady;
            tick(1);
            if (txRestart) i = 0; else if (rdy) i++;
        end
        txValid = 0; txLast = 0;
        wait (txDone); tick(1);
        if (hit) `CHK(nRestart, 1)
        else `CHK(enCnt >= exp - 2 && enCnt <= exp + 2, 1'h1)
        `CHK(txIsType, lt > 16'h05DC)
    endtask : sendFrame
    // carrier in the second gap part is ignored, through the first part it blocks
    task automatic deferFrame();
        txValid = 1; tick(150); far.carrierSense = 1;
        sendFrame(20, 1, 16'h0600, 0);
        txValid = 1; tick(400);
        `CHK(txReady | miiTxEn, 1'h0)
        far.carrierSense = 0;
        sendFrame(20, 0, 16'h05DD, 0);
    endtask : deferFrame
    // good frame, missing end delimiter, no start, J without K
    task automatic rxSeq();
        far.sendCode(`CODE_J); far.sendCode(`CODE_K); far.sendCode(5'h1E); far.sendCode(`CODE_T);
        far.sendCode(`CODE_R); far.sendCode(`CODE_J); far.sendCode(`CODE_K); far.sendCode(5'h1E);
        far.sendCode(`CODE_IDLE); far.sendCode(5'h1E); far.sendCode(`CODE_IDLE); far.sendCode(`CODE_J);
        far.sendCode(5'h1E); far.sendCode(`CODE_IDLE); tick(8);
        `CHK(nGood, 1)
        `CHK(nCrc, 1)
        `CHK(nAbort, 2)
    endtask : rxSeq
    initial begin
        tick(6);
        arst_n = 1;
        idleLine();
        sendFrame(20, 0, 16'h05DD, 0); // padded, type
        sendFrame(20, 1, 16'h05DC, 0); // unpadded, length
        sendFrame(70, 0, 16'h0800, 0);
        deferFrame();
        sendFrame(60, 0, 16'h0800, 1);
        rxSeq();
        finish_test();
    end
endmodule : fast_ethernet_mac_tx_pcs_tb_top
